// File: hw/vch_cmd.sv
// Vendor command handler: APB slave holding a command block, its decoder
// and the sequencers for address change, utilities, pass-through and
// defect-list maintenance.
// Assumes drive, utility and format engines run on CLK; pins are async.
//
// Operation
// - New address applies only at bus reset
// - Source bit clear: pinsets give address
// - Source bit set: byte 4 field gives address
// - Narrow address field is byte 4 bits 2-0
// - Opcode C2H: wide four-bit address field
// - Power loss reverts address to pinsets
// - Run bit starts selected stored utility
// - Resume bit restarts; unresumable gives check
// - Only pages 06H and 07H accepted; code compares byte 2 bits 2-0 only, so 0EH and 0FH also pass
// - EFH forwards bytes 2-3 command word
// - Status request returns two drive bytes first
// - Summary byte: selected, complete, ready, attention
// - Pass-through check reports 01/44H, keeps error
// - Delete and replace perform full format
// - Save operating parameters after maintenance completes
// - Append adds entries, remaps, no reinitialise
// - Every maintenance run erases grown list
// - Factory list not mapped to registers
// - Follows bit clear: no data-out, lists discarded
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module vch_cmd
  import vch_pkg::*;
#(
  parameter logic [7:0] OP_ID_NARROW = 8'hC1,
  parameter logic [7:0] OP_UTILITY = 8'hEE,
  parameter logic [7:0] OP_DEFECT = 8'hFD
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Pins
  input wire logic [3:0] ADDR_PINS,
  input wire logic BUS_RESET,
  output logic [3:0] TARGET_ID,
  // Drive interface
  output logic [15:0] ESDI_CMD,
  output logic ESDI_CMD_VALID,
  input wire logic ESDI_CMD_READY,
  input wire logic ESDI_STAT_VALID,
  input wire logic [7:0] ESDI_STAT_BYTE,
  input wire logic ESDI_CMPL,
  input wire logic [7:0] ESDI_SUMMARY,
  input wire logic ESDI_FAULT,
  input wire logic [7:0] ESDI_ERR_CODE,
  // Utility engine
  output logic UTIL_START,
  output logic UTIL_RESUME,
  output logic [2:0] UTIL_PAGE,
  output logic [3:0] UTIL_INDEX,
  input wire logic UTIL_CAN_RESUME,
  input wire logic UTIL_DONE,
  // Format engine
  output logic DOUT_REQ,
  input wire logic DOUT_DONE,
  output logic FMT_START,
  output logic FMT_FULL,
  input wire logic FMT_DONE,
  output logic PLIST_DISCARD,
  output logic GLIST_ERASE,
  output logic SAVE_PARAMS
);

  vch_state_t state_reg, state_next;
  logic [7:0] cdb_reg [0:9];
  logic [3:0] pins_s1_reg, pins_s2_reg;
  logic rst_s1_reg, rst_s2_reg, rst_s3_reg;
  logic done_reg, check_reg;
  logic [3:0] key_reg;
  logic [7:0] asc_reg, derr_reg;
  logic [7:0] resp_reg [0:2];
  logic [1:0] cnt_reg, stat_idx_reg;
  logic esdi_valid_reg, util_start_reg, util_resume_reg;
  logic dout_reg, fmt_start_reg, fmt_full_reg;
  logic plist_reg, glist_reg, save_reg;
  logic [31:0] prdata_reg;
  logic wr_en, rd_en, go, is_narrow, is_wide, id_load;
  logic dec_check;
  logic [3:0] dec_key;
  logic [7:0] dec_asc;
  logic [3:0] id_now, id_pend;
  logic id_src_pend, id_src_cmd;
  logic [3:0] id_addr_cmd;
  logic page_ok;

  // Overlapping opcodes would let one handler shadow another
  if (OP_ID_NARROW == OP_UTILITY || OP_ID_NARROW == OP_DEFECT
      || OP_UTILITY == OP_DEFECT || OP_ID_NARROW == VCH_OP_ID_WIDE
      || OP_ID_NARROW == VCH_OP_PASS || OP_UTILITY == VCH_OP_ID_WIDE
      || OP_UTILITY == VCH_OP_PASS || OP_DEFECT == VCH_OP_ID_WIDE
      || OP_DEFECT == VCH_OP_PASS) begin : g_op_check
    $error("opcode parameters overlap");
  end

  // ==========================================================
  // APB access; zero wait states
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  // No register exposes the factory defect list; unmapped reads error
  assign PSLVERR = PSEL && PENABLE && (PADDR[1:0] != 2'b00
                   || PADDR > VCH_OFF_DERR);
  assign go = wr_en && PADDR == VCH_OFF_CTRL && PWDATA[VCH_CTRL_GO]
              && state_reg == ST_IDLE;

  // Command block writes; ignored while a command runs
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < 10; i++) begin
        cdb_reg[i] <= 8'h00;
      end
    end else if (wr_en && state_reg == ST_IDLE) begin
      if (PADDR == VCH_OFF_CDB0) begin
        for (int i = 0; i < 4; i++) begin
          cdb_reg[i] <= PWDATA[8*i +: 8];
        end
      end else if (PADDR == VCH_OFF_CDB1) begin
        for (int i = 0; i < 4; i++) begin
          cdb_reg[4+i] <= PWDATA[8*i +: 8];
        end
      end else if (PADDR == VCH_OFF_CDB2) begin
        cdb_reg[8] <= PWDATA[7:0];
        cdb_reg[9] <= PWDATA[15:8];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      prdata_reg <= VCH_RST_WORD;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      if (PADDR == VCH_OFF_CDB0) begin
        prdata_reg <= {cdb_reg[3], cdb_reg[2], cdb_reg[1], cdb_reg[0]};
      end else if (PADDR == VCH_OFF_CDB1) begin
        prdata_reg <= {cdb_reg[7], cdb_reg[6], cdb_reg[5], cdb_reg[4]};
      end else if (PADDR == VCH_OFF_CDB2) begin
        prdata_reg <= {16'h0000, cdb_reg[9], cdb_reg[8]};
      end else if (PADDR == VCH_OFF_STAT) begin
        prdata_reg <= {8'h00, asc_reg, 4'h0, key_reg, 5'h00, check_reg,
                       state_reg != ST_IDLE, done_reg};
      end else if (PADDR == VCH_OFF_RESP) begin
        prdata_reg <= {6'h00, cnt_reg, resp_reg[2], resp_reg[1],
                       resp_reg[0]};
      end else if (PADDR == VCH_OFF_ID) begin
        prdata_reg <= {16'h0000, id_pend, 3'h0, id_src_pend, 4'h0, id_now};
      end else if (PADDR == VCH_OFF_DERR) begin
        prdata_reg <= {24'h000000, derr_reg};
      end else begin
        prdata_reg <= VCH_RST_WORD;
      end
    end
  end
  assign PRDATA = prdata_reg;

  // ==========================================================
  // Pin synchronisers
  // Pinset sync runs through reset so power-up reads settled pins
  always_ff @(posedge CLK) begin
    pins_s1_reg <= ADDR_PINS;
    pins_s2_reg <= pins_s1_reg;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
      rst_s3_reg <= 1'b0;
    end else begin
      rst_s1_reg <= BUS_RESET;
      rst_s2_reg <= rst_s1_reg;
      rst_s3_reg <= rst_s2_reg;
    end
  end

  // ==========================================================
  // Address change commands
  assign is_narrow = cdb_reg[0] == OP_ID_NARROW;
  assign is_wide = cdb_reg[0] == VCH_OP_ID_WIDE;
  assign id_load = state_reg == ST_DECODE && (is_narrow || is_wide);
  assign id_src_cmd = is_wide ? cdb_reg[4][VCH_B4_IDSRC_W]
                              : cdb_reg[4][VCH_B4_IDSRC_N];
  assign id_addr_cmd = is_wide ? cdb_reg[4][3:0]
                               : {1'b0, cdb_reg[4][2:0]};

  vch_id_sel u_id (
    .clk(CLK),
    .rst(RST),
    .pins_id(pins_s2_reg),
    .bus_reset(rst_s2_reg && !rst_s3_reg),
    .cmd_load(id_load),
    .cmd_src(id_src_cmd),
    .cmd_addr(id_addr_cmd),
    .cur_id(id_now),
    .pend_src(id_src_pend),
    .pend_addr(id_pend)
  );
  assign TARGET_ID = id_now;

  // ==========================================================
  // Decode and sequencing
  assign page_ok = cdb_reg[2][2:0] == VCH_PAGE_LO
                   || cdb_reg[2][2:0] == VCH_PAGE_HI;

  always_comb begin
    state_next = state_reg;
    dec_check = 1'b0;
    dec_key = VCH_KEY_NONE;
    dec_asc = VCH_ASC_NONE;
    case (state_reg)
      ST_IDLE: begin
        if (go) begin
          state_next = ST_DECODE;
        end
      end
      ST_DECODE: begin
        state_next = ST_FINISH;
        if (is_narrow || is_wide) begin
          state_next = ST_FINISH;
        end else if (cdb_reg[0] == OP_UTILITY) begin
          if (!page_ok) begin
            dec_check = 1'b1;
          end else if (cdb_reg[1][VCH_B1_RESUME] && !UTIL_CAN_RESUME) begin
            dec_check = 1'b1;
          end else if (cdb_reg[1][VCH_B1_RESUME]
                       || cdb_reg[1][VCH_B1_RUN]) begin
            state_next = ST_UTIL_RUN;
          end
          dec_key = dec_check ? VCH_KEY_ILLEGAL : VCH_KEY_NONE;
          dec_asc = dec_check ? VCH_ASC_BAD_FIELD : VCH_ASC_NONE;
        end else if (cdb_reg[0] == VCH_OP_PASS) begin
          state_next = ST_ESDI_SEND;
        end else if (cdb_reg[0] == OP_DEFECT) begin
          state_next = cdb_reg[1][VCH_B1_FOLLOWS] ? ST_FMT_DOUT
                                                  : ST_FMT_RUN;
        end else begin
          dec_check = 1'b1;
          dec_key = VCH_KEY_ILLEGAL;
          dec_asc = VCH_ASC_BAD_OP;
        end
      end
      ST_ESDI_SEND: begin
        if (ESDI_CMD_READY) begin
          state_next = ST_ESDI_WAIT;
        end
      end
      ST_ESDI_WAIT: begin
        // No timeout here; a command that never completes hangs the block
        if (ESDI_CMPL) begin
          state_next = ST_FINISH;
        end
      end
      ST_UTIL_RUN: begin
        if (UTIL_DONE) begin
          state_next = ST_FINISH;
        end
      end
      ST_FMT_DOUT: begin
        if (DOUT_DONE) begin
          state_next = ST_FMT_RUN;
        end
      end
      ST_FMT_RUN: begin
        if (FMT_DONE) begin
          state_next = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Completion status; a finishing command wins over a software clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      done_reg <= 1'b0;
    end else if (state_reg == ST_FINISH) begin
      done_reg <= 1'b1;
    end else if (go || (wr_en && PADDR == VCH_OFF_STAT
                        && PWDATA[VCH_STAT_DONE])) begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      check_reg <= 1'b0;
      key_reg <= VCH_KEY_NONE;
      asc_reg <= VCH_ASC_NONE;
    end else if (state_reg == ST_DECODE) begin
      check_reg <= dec_check;
      key_reg <= dec_key;
      asc_reg <= dec_asc;
    end else if (state_reg == ST_ESDI_WAIT && ESDI_CMPL && ESDI_FAULT) begin
      check_reg <= 1'b1;
      key_reg <= VCH_KEY_RECOV;
      asc_reg <= VCH_ASC_DRIVE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      derr_reg <= 8'h00;
    end else if (state_reg == ST_ESDI_WAIT && ESDI_CMPL) begin
      derr_reg <= ESDI_ERR_CODE;
    end
  end

  // Answer bytes: drive status first, summary last
  always_ff @(posedge CLK) begin
    if (RST) begin
      resp_reg[0] <= 8'h00;
      resp_reg[1] <= 8'h00;
      resp_reg[2] <= 8'h00;
      cnt_reg <= 2'h0;
      stat_idx_reg <= 2'h0;
    end else if (state_reg == ST_DECODE) begin
      cnt_reg <= 2'h0;
      stat_idx_reg <= 2'h0;
    end else if (state_reg == ST_ESDI_WAIT) begin
      if (ESDI_STAT_VALID && cdb_reg[1][VCH_B1_STATREQ]
          && stat_idx_reg < 2'h2) begin
        resp_reg[stat_idx_reg] <= ESDI_STAT_BYTE;
        stat_idx_reg <= stat_idx_reg + 2'h1;
      end
      if (ESDI_CMPL) begin
        resp_reg[2] <= {4'h0, ESDI_SUMMARY[3:0]};
        cnt_reg <= cdb_reg[1][VCH_B1_STATREQ] ? VCH_CNT_FULL
                                              : VCH_CNT_SUMMARY;
      end
    end
  end

  // ==========================================================
  // Drive command word
  always_ff @(posedge CLK) begin
    if (RST) begin
      esdi_valid_reg <= 1'b0;
    end else if (state_reg == ST_DECODE && state_next == ST_ESDI_SEND) begin
      esdi_valid_reg <= 1'b1;
    end else if (ESDI_CMD_READY) begin
      esdi_valid_reg <= 1'b0;
    end
  end
  assign ESDI_CMD_VALID = esdi_valid_reg;
  assign ESDI_CMD = {cdb_reg[2], cdb_reg[3]};

  // ==========================================================
  // Utility launch
  always_ff @(posedge CLK) begin
    if (RST) begin
      util_start_reg <= 1'b0;
      util_resume_reg <= 1'b0;
    end else begin
      util_start_reg <= state_reg == ST_DECODE && state_next == ST_UTIL_RUN
                        && !cdb_reg[1][VCH_B1_RESUME];
      util_resume_reg <= state_reg == ST_DECODE && state_next == ST_UTIL_RUN
                         && cdb_reg[1][VCH_B1_RESUME];
    end
  end
  assign UTIL_START = util_start_reg;
  assign UTIL_RESUME = util_resume_reg;
  assign UTIL_PAGE = cdb_reg[2][2:0];
  assign UTIL_INDEX = cdb_reg[3][3:0];

  // ==========================================================
  // Defect-list maintenance
  always_ff @(posedge CLK) begin
    if (RST) begin
      dout_reg <= 1'b0;
      fmt_start_reg <= 1'b0;
      fmt_full_reg <= 1'b0;
      plist_reg <= 1'b0;
      glist_reg <= 1'b0;
      save_reg <= 1'b0;
    end else begin
      dout_reg <= state_next == ST_FMT_DOUT;
      fmt_start_reg <= state_next == ST_FMT_RUN && state_reg != ST_FMT_RUN;
      if (state_reg == ST_DECODE && cdb_reg[0] == OP_DEFECT) begin
        // Append only when a list follows and replace is clear
        fmt_full_reg <= !(cdb_reg[1][VCH_B1_FOLLOWS]
                          && !cdb_reg[1][VCH_B1_REPLACE]);
      end
      plist_reg <= state_reg == ST_DECODE && cdb_reg[0] == OP_DEFECT
                   && !cdb_reg[1][VCH_B1_FOLLOWS];
      glist_reg <= state_reg == ST_DECODE && cdb_reg[0] == OP_DEFECT;
      save_reg <= state_reg == ST_FMT_RUN && FMT_DONE;
    end
  end
  assign DOUT_REQ = dout_reg;
  assign FMT_START = fmt_start_reg;
  assign FMT_FULL = fmt_full_reg;
  assign PLIST_DISCARD = plist_reg;
  assign GLIST_ERASE = glist_reg;
  assign SAVE_PARAMS = save_reg;

  // ==========================================================
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_bad_opcode: assert property (state_reg == ST_DECODE && !is_narrow
    && !is_wide && cdb_reg[0] != OP_UTILITY && cdb_reg[0] != VCH_OP_PASS
    && cdb_reg[0] != OP_DEFECT |=> check_reg && key_reg == VCH_KEY_ILLEGAL
    && asc_reg == VCH_ASC_BAD_OP)
    else $error("unsupported opcode not rejected");
  a_page_reject: assert property (state_reg == ST_DECODE
    && cdb_reg[0] == OP_UTILITY && !page_ok
    |=> check_reg && asc_reg == VCH_ASC_BAD_FIELD && !UTIL_START)
    else $error("bad page accepted");
  a_resume_reject: assert property (state_reg == ST_DECODE
    && cdb_reg[0] == OP_UTILITY && page_ok && cdb_reg[1][VCH_B1_RESUME]
    && !UTIL_CAN_RESUME |=> check_reg ##1 !UTIL_RESUME)
    else $error("unresumable utility not rejected");
  a_util_launch: assert property (state_reg == ST_DECODE
    && state_next == ST_UTIL_RUN |=> UTIL_START ^ UTIL_RESUME)
    else $error("utility not launched");
  a_cmd_word: assert property (ESDI_CMD_VALID && !ESDI_CMD_READY
    |=> $stable(ESDI_CMD))
    else $error("drive command word altered");
  a_summary_byte: assert property (state_reg == ST_ESDI_WAIT && ESDI_CMPL
    |=> resp_reg[2][3:0] == $past(ESDI_SUMMARY[3:0])
    && done_reg == 1'b0 ##1 done_reg)
    else $error("summary byte wrong");
  a_stat_count: assert property (state_reg == ST_ESDI_WAIT && ESDI_CMPL
    && cdb_reg[1][VCH_B1_STATREQ] |=> cnt_reg == VCH_CNT_FULL)
    else $error("status byte count wrong");
  a_drive_sense: assert property (state_reg == ST_ESDI_WAIT && ESDI_CMPL
    && ESDI_FAULT |=> key_reg == VCH_KEY_RECOV && asc_reg == VCH_ASC_DRIVE
    && derr_reg == $past(ESDI_ERR_CODE))
    else $error("pass-through sense wrong");
  a_glist_erase: assert property (state_reg == ST_DECODE
    && cdb_reg[0] == OP_DEFECT |=> GLIST_ERASE)
    else $error("grown list not erased");
  a_no_dataout: assert property (state_reg == ST_DECODE
    && cdb_reg[0] == OP_DEFECT && !cdb_reg[1][VCH_B1_FOLLOWS]
    |=> PLIST_DISCARD && !DOUT_REQ && FMT_START && FMT_FULL)
    else $error("delete option sequence wrong");
  a_save_after: assert property (state_reg == ST_FMT_RUN && FMT_DONE
    |=> SAVE_PARAMS ##1 done_reg)
    else $error("parameters not saved");

  c_pass_stat: cover property (state_reg == ST_ESDI_WAIT && ESDI_CMPL
    && cdb_reg[1][VCH_B1_STATREQ]);
  c_append: cover property (FMT_START && !FMT_FULL);
  c_util_run: cover property (UTIL_START ##[1:100] UTIL_DONE);

endmodule

// File: hw/vch_id_sel.sv
// Target bus address selection: pending source and address, applied on bus reset.
// Assumes pins and bus reset already synchronised to clk by the caller.
`timescale 1ns/1ps
module vch_id_sel
  import vch_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs
  input wire logic [3:0] pins_id,
  input wire logic bus_reset,
  input wire logic cmd_load,
  input wire logic cmd_src,
  input wire logic [3:0] cmd_addr,
  // Outputs
  output logic [3:0] cur_id,
  output logic pend_src,
  output logic [3:0] pend_addr
);

  logic pend_src_reg;
  logic [3:0] pend_addr_reg;
  logic [3:0] cur_id_reg;
  logic boot_reg;

  // ==========================================================
  // Pending selection; power-on reset forgets any commanded address
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_src_reg <= 1'b0;
      pend_addr_reg <= VCH_RST_ID;
    end else if (cmd_load) begin
      pend_src_reg <= cmd_src;
      pend_addr_reg <= cmd_addr;
    end
  end

  // ==========================================================
  // Live address changes only at a bus reset or just after power-up
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_reg <= 1'b1;
      cur_id_reg <= VCH_RST_ID;
    end else if (boot_reg || bus_reset) begin
      boot_reg <= 1'b0;
      if (pend_src_reg && !boot_reg) begin
        cur_id_reg <= pend_addr_reg;
      end else begin
        cur_id_reg <= pins_id;
      end
    end
  end

  assign cur_id = cur_id_reg;
  assign pend_src = pend_src_reg;
  assign pend_addr = pend_addr_reg;

  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_id_holds: assert property (!bus_reset && !boot_reg |=> $stable(cur_id_reg))
    else $error("address changed without bus reset");
  a_id_from_pins: assert property (bus_reset && !pend_src_reg && !boot_reg
    |=> cur_id_reg == $past(pins_id))
    else $error("pinset address not taken");
  a_id_from_cmd: assert property (bus_reset && pend_src_reg && !boot_reg
    |=> cur_id_reg == $past(pend_addr_reg))
    else $error("commanded address not taken");
  c_id_switch: cover property (cmd_load && cmd_src ##[1:50] bus_reset);

endmodule

// File: hw/vch_pkg.sv
// Package: constants, states and codes of the vendor command handler.
// Assumes a single 100 MHz clock domain with a synchronous, active-high reset.
package vch_pkg;

  // ==========================================================
  // Register map (byte addresses on APB)
  localparam logic [7:0] VCH_OFF_CDB0 = 8'h00;
  localparam logic [7:0] VCH_OFF_CDB1 = 8'h04;
  localparam logic [7:0] VCH_OFF_CDB2 = 8'h08;
  localparam logic [7:0] VCH_OFF_CTRL = 8'h0C;
  localparam logic [7:0] VCH_OFF_STAT = 8'h10;
  localparam logic [7:0] VCH_OFF_RESP = 8'h14;
  localparam logic [7:0] VCH_OFF_ID = 8'h18;
  localparam logic [7:0] VCH_OFF_DERR = 8'h1C;

  // ==========================================================
  // Field positions
  localparam int VCH_CTRL_GO = 0;
  localparam int VCH_STAT_DONE = 0;
  localparam int VCH_STAT_BUSY = 1;
  localparam int VCH_STAT_CHECK = 2;
  localparam int VCH_STAT_KEY = 8;
  localparam int VCH_STAT_ASC = 16;
  localparam int VCH_RESP_CNT = 24;
  localparam int VCH_ID_SRC = 8;
  localparam int VCH_ID_NEW = 12;
  localparam int VCH_B1_STATREQ = 0;
  localparam int VCH_B1_RUN = 0;
  localparam int VCH_B1_RESUME = 2;
  localparam int VCH_B1_REPLACE = 3;
  localparam int VCH_B1_FOLLOWS = 4;
  localparam int VCH_B4_IDSRC_N = 3;
  localparam int VCH_B4_IDSRC_W = 4;

  // ==========================================================
  // Opcodes, pages and sense codes
  localparam logic [7:0] VCH_OP_ID_WIDE = 8'hC2;
  localparam logic [7:0] VCH_OP_PASS = 8'hEF;
  localparam logic [2:0] VCH_PAGE_LO = 3'h6;
  localparam logic [2:0] VCH_PAGE_HI = 3'h7;
  localparam logic [3:0] VCH_KEY_NONE = 4'h0;
  localparam logic [3:0] VCH_KEY_RECOV = 4'h1;
  localparam logic [3:0] VCH_KEY_ILLEGAL = 4'h5;
  localparam logic [7:0] VCH_ASC_NONE = 8'h00;
  localparam logic [7:0] VCH_ASC_BAD_OP = 8'h20;
  localparam logic [7:0] VCH_ASC_BAD_FIELD = 8'h24;
  localparam logic [7:0] VCH_ASC_DRIVE = 8'h44;
  localparam logic [1:0] VCH_CNT_SUMMARY = 2'h1;
  localparam logic [1:0] VCH_CNT_FULL = 2'h3;

  // ==========================================================
  // Reset values
  localparam logic [31:0] VCH_RST_WORD = 32'h0000_0000;
  localparam logic [3:0] VCH_RST_ID = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DECODE,
    ST_ESDI_SEND,
    ST_ESDI_WAIT,
    ST_UTIL_RUN,
    ST_FMT_DOUT,
    ST_FMT_RUN,
    ST_FINISH
  } vch_state_t;

endpackage

// File: tb/testbench.sv
// Self-checking bench: commands over APB, random fields and corners.
// Assumes vch_pkg, vch_cmd and the far-side model compiled first.
`timescale 1ns/1ps
module testbench;
  import vch_pkg::*;
  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic BUS_RESET = 0, UTIL_CAN_RESUME = 0, fault_en = 0, e, sd, full;
  logic PREADY, PSLVERR, ESDI_CMD_VALID, ESDI_CMD_READY, ESDI_STAT_VALID;
  logic ESDI_CMPL, ESDI_FAULT, UTIL_START, UTIL_RESUME, UTIL_DONE;
  logic DOUT_REQ, DOUT_DONE, FMT_START, FMT_FULL, FMT_DONE;
  logic PLIST_DISCARD, GLIST_ERASE, SAVE_PARAMS;
  logic [7:0] PADDR = 8'h00, ESDI_STAT_BYTE, ESDI_SUMMARY, ESDI_ERR_CODE;
  logic [31:0] PWDATA = 32'h0, PRDATA, q;
  logic [3:0] ADDR_PINS = 4'h0, TARGET_ID, UTIL_INDEX, a, old;
  logic [2:0] UTIL_PAGE;
  logic [15:0] ESDI_CMD, cw;
  int err_count = 0, cmp_count = 0, ng, ns, np, seed = 32'h6c309d17;
  vch_cmd uut (.*);
  vch_far_model far (.*);
  always #5 CLK = ~CLK;
  always @(posedge CLK) begin
    ng += GLIST_ERASE;
    ns += SAVE_PARAMS;
    np += PLIST_DISCARD;
    sd |= DOUT_REQ;
    if (FMT_START) full = FMT_FULL;
  end
  // ==========================================================
  // Checks and bus tasks
  task automatic chk(input string s, input logic [31:0] g, x);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    chk("wait", 32'(PREADY !== 1'b1), 32'h0);
    if (PREADY !== 1'b1) stop_test();
    @(posedge CLK);
  endtask
  task automatic run(input logic [31:0] w0, w1);
    int n;
    n = 0;
    apb(1, VCH_OFF_CDB0, w0);
    apb(1, VCH_OFF_CDB1, w1);
    apb(1, VCH_OFF_CTRL, 32'h1);
    do begin
      apb(0, VCH_OFF_STAT, 32'h0);
      n++;
    end while (q[VCH_STAT_DONE] !== 1'b1 && n < 50);
    if (q[VCH_STAT_DONE] !== 1'b1) begin
      chk("done", q, 32'h1);
      stop_test();
    end
  endtask
  function automatic logic [31:0] fst(input logic c, input logic [3:0] k,
      input logic [7:0] s);
    return c ? {8'h0, s, 4'h0, k, 8'h05} : 32'h1;
  endfunction
  function automatic logic [3:0] fid(input logic w, sr, input logic [3:0] d);
    return !sr ? ADDR_PINS : (w ? d : {1'b0, d[2:0]});
  endfunction
  initial begin
    ADDR_PINS <= 4'($random(seed));
    repeat (2) @(posedge CLK);
    RST <= 0;
    repeat (3) @(posedge CLK);
    for (int i = 0; i < 6; i++) begin
      a = 4'($random(seed));
      old = TARGET_ID;
      // New pins must wait for the next bus reset
      ADDR_PINS <= 4'($random(seed));
      // Narrow form puts a[3] on the wide source bit, which must be ignored
      run(i[1] ? 32'hC2 : 32'hC1,
          i[1] ? {27'h0, i[0], a} : {27'h0, a[3], i[0], a[2:0]});
      chk("id held", 32'(TARGET_ID), 32'(old));
      BUS_RESET <= 1;
      repeat (2) @(posedge CLK);
      BUS_RESET <= 0;
      repeat (5) @(posedge CLK);
      chk("new id", 32'(TARGET_ID), 32'(fid(i[1], i[0], a)));
    end
    RST <= 1;
    repeat (2) @(posedge CLK);
    RST <= 0;
    repeat (3) @(posedge CLK);
    chk("power id", 32'(TARGET_ID), 32'(ADDR_PINS));
    $display("end address tests");
    for (int i = 0; i < 10; i++) begin
      a = 4'($random(seed));
      UTIL_CAN_RESUME <= i == 9;
      cw = {4'h0, a, 5'h0, i < 8 ? 3'(i) : 3'h6};
      run({cw, i < 8 ? 8'h01 : 8'h04, 8'hEE}, 32'h0);
      chk("util", q, fst(cw[2:0] < 6 || i == 8, 4'h5, 8'h24));
      chk("sel", 32'({UTIL_PAGE, UTIL_INDEX}), 32'({cw[2:0], a}));
    end
    $display("end utility tests");
    for (int i = 0; i < 3; i++) begin
      cw = 16'($random(seed));
      fault_en <= i == 2;
      run({cw[7:0], cw[15:8], 7'h0, i != 1, 8'hEF}, 32'h0);
      chk("pass", q, fst(i == 2, 4'h1, 8'h44));
      chk("cmd", 32'(ESDI_CMD), 32'(cw));
      apb(0, VCH_OFF_RESP, 32'h0);
      chk("resp", q & (i == 1 ? 32'h03FF0000 : 32'h03FFFFFF),
          i == 1 ? 32'h01050000 : 32'h0305A3A2);
      apb(0, VCH_OFF_DERR, 32'h0);
      chk("derr", q, 32'h3C);
    end
    $display("end pass-through tests");
    for (int i = 0; i < 3; i++) begin
      ng = 0;
      ns = 0;
      np = 0;
      sd = 0;
      run({16'h0, 3'h0, i != 0, i == 2, 3'h0, 8'hFD}, 32'h0);
      chk("glist", 32'(ng), 32'h1);
      chk("save", 32'(ns), 32'h1);
      chk("plist", 32'(np), 32'(i == 0));
      chk("dout", 32'(sd), 32'(i != 0));
      chk("full", 32'(full), 32'(i != 1));
    end
    $display("end defect tests");
    run(32'h000000A0, 32'h0);
    chk("bad op", q, fst(1'b1, 4'h5, 8'h20));
    apb(0, 8'h20, 32'h0);
    chk("unmapped", {q[30:0], e}, 32'h1);
    apb(1, VCH_OFF_STAT, 32'h1);
    apb(0, VCH_OFF_STAT, 32'h0);
    chk("w1c", q, fst(1'b1, 4'h5, 8'h20) ^ 32'h1);
    $display("end decode tests");
    stop_test();
  end
endmodule

// File: tb/vch_far_model.sv
// Far side: drive interface, utility and format engines.
// Assumes the handler's clock and reset; answers are one-cycle pulses except ESDI_STAT_VALID, held two cycles.
`timescale 1ns/1ps
module vch_far_model (
  // Clock, reset, test control
  input wire logic CLK,
  input wire logic RST,
  input wire logic fault_en,
  // Requests
  input wire logic ESDI_CMD_VALID,
  input wire logic UTIL_START,
  input wire logic UTIL_RESUME,
  input wire logic DOUT_REQ,
  input wire logic FMT_START,
  // Answers
  output logic ESDI_CMD_READY,
  output logic UTIL_DONE,
  output logic DOUT_DONE,
  output logic FMT_DONE,
  output logic ESDI_STAT_VALID,
  output logic ESDI_CMPL,
  output logic ESDI_FAULT,
  output logic [7:0] ESDI_STAT_BYTE,
  output logic [7:0] ESDI_SUMMARY,
  output logic [7:0] ESDI_ERR_CODE
);
  logic [2:0] cnt;
  // ==========================================================
  // Accept, two status bytes, then completion
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt <= 3'h0;
      ESDI_CMD_READY <= 1'b0;
      UTIL_DONE <= 1'b0;
      DOUT_DONE <= 1'b0;
      FMT_DONE <= 1'b0;
    end else begin
      ESDI_CMD_READY <= ESDI_CMD_VALID & ~ESDI_CMD_READY;
      cnt <= ESDI_CMD_READY ? 3'h1 : (cnt == 3'h4 ? 3'h0 : cnt + 3'(cnt != 0));
      UTIL_DONE <= UTIL_START | UTIL_RESUME;
      DOUT_DONE <= DOUT_REQ & ~DOUT_DONE;
      FMT_DONE <= FMT_START;
    end
  end
  assign ESDI_STAT_VALID = cnt == 3'h2 || cnt == 3'h3;
  assign ESDI_CMPL = cnt == 3'h4;
  assign ESDI_FAULT = ESDI_CMPL & fault_en;
  // Idle lines keep moving so a stale byte never matches
  assign ESDI_STAT_BYTE = {5'h14, cnt} ^ {8{~ESDI_STAT_VALID}};
  assign ESDI_SUMMARY = ESDI_CMPL ? 8'hF5 : {5'h0, cnt};
  assign ESDI_ERR_CODE = ESDI_CMPL ? 8'h3C : {cnt, 5'h0};
endmodule
